/* File: tb/comparator_reference_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module comparator_reference_control_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cmp_a = 1'b0, cmp_b = 1'b0, hf = 1'b0, vd = 1'b0, bo = 1'b0;
	logic [7:0] pins = 8'h00;
	wire logic awready, wready, bvalid, arready, rvalid, mm_upd, a_rsel, b_rsel, a_ni, b_ni;
	wire logic b_pin, b_oe, d_en, d_low, d_ext, d_clamp, d_pin, r_doe, r_idis, f_on, f_st;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0] d_lvl;
	wire logic [4:0] d_tap;
	int errors = 0, total_checks = 0, cycles = 0, mm_count = 0, n, i, mmb;
	logic [7:0] m_sel, m_div, m_pc, m_an, d;
	logic [31:0] rd;
	logic [1:0] rsp;

	crc_top dut (.MCLK(mclk), .RST_N(rst_n), .S_AWADDR(awaddr), .S_AWVALID(awvalid),
		.S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(4'h1), .S_WVALID(wvalid),
		.S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
		.S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
		.S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .CMP_A_RESULT(cmp_a),
		.CMP_B_RESULT(cmp_b), .PORT_PIN_IN(pins), .HF_OSC_ENABLED(hf), .VDETECT_ENABLED(vd),
		.BROWNOUT_ENABLED(bo), .MISMATCH_UPDATE(mm_upd), .CMP_A_REF_SEL_DIVIDER(a_rsel),
		.CMP_B_REF_SEL_DIVIDER(b_rsel), .CMP_A_NONINV_INTERNAL(a_ni),
		.CMP_B_NONINV_INTERNAL(b_ni), .CMP_B_PIN_OUT(b_pin), .CMP_B_PIN_OE(b_oe),
		.DIV_ENABLE(d_en), .DIV_RANGE_LOW(d_low), .DIV_SOURCE_EXTERNAL(d_ext),
		.DIV_LEVEL(d_lvl), .DIV_TAP(d_tap), .DIV_CLAMP(d_clamp), .DIV_PIN_CONNECT(d_pin),
		.REF_PIN_DIGITAL_OE(r_doe), .REF_PIN_INPUT_DISABLE(r_idis), .FIXED_REF_ON(f_on),
		.FIXED_REF_STABLE(f_st));

	always #10 mclk = ~mclk;

	// hang guard, well above the roughly 1500 cycles the run needs
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (mm_upd)
			mm_count = mm_count + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			end_of_test();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask

	// address and data offered together, each released when its own ready is seen
	task wr(input logic [31:0] a, input logic [7:0] v);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			aw_ok = aw_ok | awready;
			w_ok = w_ok | wready;
		end
		do @(posedge mclk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task rdr(input logic [31:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge mclk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	task rchk(input logic [31:0] a, input logic [7:0] exp);
		rdr(a);
		chk(rsp, crc_pkg::RESP_OKAY, "read resp");
		chk(rd, {24'h0, exp}, "read data");
	endtask

	task do_reset;
		rst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		m_sel = 8'h00;
		m_div = 8'h00;
		m_pc = crc_pkg::RST_PIN_CTRL;
		m_an = crc_pkg::RST_ANALOG;
		settle();
	endtask

	initial
	begin
		void'($urandom(88963));
		do_reset();
		rchk(crc_pkg::OFF_DIVIDER_CTRL, 8'h00);
		rchk(crc_pkg::OFF_FIXED_CTRL, 8'h00);
		rchk(crc_pkg::OFF_CMP_PIN_CTRL, m_pc);
		chk(d_tap, 8, "reset tap");
		chk({d_clamp, d_pin, f_on}, 0, "reset outs");
		$display("reset test done");
		for (i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			cmp_a <= 1'($urandom_range(1));
			cmp_b <= 1'($urandom_range(1));
			d = 8'($urandom);
			wr(crc_pkg::OFF_MIRROR_REFSEL, d);
			m_sel = d & crc_pkg::MIRROR_WMASK;
			mmb = mm_count;
			rchk(crc_pkg::OFF_MIRROR_REFSEL, {cmp_a, cmp_b, m_sel[5:4], 4'h0});
			settle();
			chk(a_rsel, m_sel[5], "ref sel a");
			chk(b_rsel, m_sel[4], "ref sel b");
			chk(mm_count, mmb, "mirror read latch");
		end
		rchk(crc_pkg::OFF_CMP_PIN_CTRL, m_pc);
		settle();
		chk(mm_count, mmb + 1, "ctrl read latch");
		$display("mirror test done");
		for (i = 0; i < 24; i++)
		begin
			d = (i == 0) ? 8'h20 : (i == 1) ? 8'hcf : 8'($urandom);
			wr(crc_pkg::OFF_DIVIDER_CTRL, d);
			m_div = d;
			settle();
			chk(d_en, m_div[7], "div enable");
			chk({d_low, d_lvl}, {m_div[5], m_div[3:0]}, "range level");
			chk(d_ext, m_div[4], "source");
			chk(d_tap, m_div[5] ? {1'b0, m_div[3:0]} : 5'h08 + m_div[3:0], "tap");
			chk(d_clamp, !m_div[7] && m_div[5] && m_div[3:0] == 4'h0, "clamp");
			chk({d_pin, r_idis}, {2{m_div[6]}}, "pin route");
			rchk(crc_pkg::OFF_DIVIDER_CTRL, m_div);
		end
		$display("divider test done");
		for (i = 0; i < 8; i++)
		begin
			@(posedge mclk);
			pins <= 8'($urandom);
			m_an = 8'($urandom);
			wr(crc_pkg::OFF_ANALOG_SELECT, m_an);
			m_div = i[0] ? 8'h40 : 8'h00;
			wr(crc_pkg::OFF_DIVIDER_CTRL, m_div);
			settle();
			d = pins & ~m_an & ~(m_div[6] ? 8'(1 << crc_pkg::REF_PIN_IDX) : 8'h00);
			rchk(crc_pkg::OFF_PORT_READ, d);
		end
		$display("port test done");
		for (i = 0; i < 64; i++)
		begin
			wr(crc_pkg::OFF_CMP_PIN_CTRL, i[7:0]);
			m_pc = i[7:0] & crc_pkg::PIN_CTRL_WMASK;
			settle();
			chk(b_oe, m_pc[0] && m_pc[1] && !m_pc[2], "cmp b oe");
			chk({a_ni, b_ni}, {m_pc[4], m_pc[5]}, "noninv");
			chk(r_doe, 0, "ref pin override");
			if (m_pc[0] && m_pc[1] && !m_pc[2])
				chk(b_pin, cmp_b, "cmp b pin");
		end
		wr(crc_pkg::OFF_DIVIDER_CTRL, 8'h00);
		m_div = 8'h00;
		settle();
		chk(r_doe, !m_pc[3], "ref pin released");
		wr(crc_pkg::OFF_CMP_PIN_CTRL, 8'h00);
		m_pc = 8'h00;
		settle();
		chk(r_doe, !m_pc[3], "ref pin driven");
		$display("pin test done");
		wr(crc_pkg::OFF_FIXED_CTRL, 8'hff);
		settle();
		chk({f_on, f_st}, 2'b10, "fixed on");
		n = 3;
		while (!f_st && n < 700)
		begin
			@(posedge mclk);
			n++;
		end
		#1;
		chk(n >= 490 && n <= 510, 1, "settle time");
		rchk(crc_pkg::OFF_FIXED_CTRL, 8'hc0);
		wr(crc_pkg::OFF_FIXED_CTRL, 8'h00);
		settle();
		chk({f_on, f_st}, 2'b00, "fixed off");
		for (i = 0; i < 3; i++)
		begin
			@(posedge mclk);
			{hf, vd, bo} <= 3'(1 << i);
			repeat (5) @(posedge mclk);
			#1;
			chk(f_on, 1, "default on");
			@(posedge mclk);
			{hf, vd, bo} <= 3'h0;
			repeat (5) @(posedge mclk);
			#1;
			chk(f_on, 0, "default off");
		end
		rchk(crc_pkg::OFF_DIVIDER_CTRL, m_div);
		$display("fixed test done");
		wr(32'h20, 8'hff);
		chk(rsp, crc_pkg::RESP_SLVERR, "unmapped write");
		rdr(32'h20);
		chk(rsp, crc_pkg::RESP_SLVERR, "unmapped read resp");
		chk(rd, 32'h0, "unmapped read data");
		wr(crc_pkg::OFF_DIVIDER_CTRL, 8'hdf);
		wr(crc_pkg::OFF_FIXED_CTRL, 8'h80);
		do_reset();
		rchk(crc_pkg::OFF_DIVIDER_CTRL, 8'h00);
		rchk(crc_pkg::OFF_FIXED_CTRL, 8'h00);
		chk({d_tap, d_low, d_pin}, {5'h08, 2'b00}, "second reset");
		$display("unmapped and reset test done");
		end_of_test();
	end
endmodule // comparator_reference_control_tb
`default_nettype wire

/* File: verilog/crc_pkg.sv */
`default_nettype none
package crc_pkg;
	// register byte offsets on the bus
	localparam logic [31:0] OFF_MIRROR_REFSEL = 32'h0000_0000;
	localparam logic [31:0] OFF_DIVIDER_CTRL = 32'h0000_0004;
	localparam logic [31:0] OFF_FIXED_CTRL = 32'h0000_0008;
	localparam logic [31:0] OFF_CMP_PIN_CTRL = 32'h0000_000c;
	localparam logic [31:0] OFF_PORT_READ = 32'h0000_0010;
	localparam logic [31:0] OFF_ANALOG_SELECT = 32'h0000_0014;

	// mirror and reference select register
	localparam int MIR_A_BIT = 7;
	localparam int MIR_B_BIT = 6;
	localparam int RSEL_A_BIT = 5;
	localparam int RSEL_B_BIT = 4;
	localparam logic [7:0] MIRROR_WMASK = 8'h30;

	// divider reference control register
	localparam int DIV_EN_BIT = 7;
	localparam int DIV_OE_BIT = 6;
	localparam int DIV_RANGE_BIT = 5;
	localparam int DIV_SRC_BIT = 4;
	localparam int DIV_LEVEL_MSB = 3;

	// fixed reference control register
	localparam int FIX_EN_BIT = 7;
	localparam int FIX_ST_BIT = 6;

	// comparator pin control register
	localparam int PC_B_OE_BIT = 0;
	localparam int PC_B_ON_BIT = 1;
	localparam int PC_B_DIR_BIT = 2;
	localparam int PC_REF_DIR_BIT = 3;
	localparam int PC_A_NONINV_BIT = 4;
	localparam int PC_B_NONINV_BIT = 5;
	localparam logic [7:0] PIN_CTRL_WMASK = 8'h3f;

	// port pin positions
	localparam int REF_PIN_IDX = 2;
	localparam int CMP_B_PIN_IDX = 5;

	// reset values
	localparam logic [7:0] RST_MIRROR = 8'h00;
	localparam logic [7:0] RST_DIVIDER = 8'h00;
	localparam logic [7:0] RST_PIN_CTRL = 8'h0c;
	localparam logic [7:0] RST_ANALOG = 8'hff;

	// high range tap offset
	localparam logic [4:0] DIV_HIGH_BASE = 5'h08;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// fixed reference settling time
	localparam int CLK_PERIOD_NS = 20;
	localparam int FIX_SETTLE_NS = 10000;
	localparam int FIX_SETTLE_CYCLES = (FIX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 10;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(FIX_SETTLE_CYCLES - 1);
endpackage
`default_nettype wire

/* File: verilog/crc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module crc_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [31:0] S_AWADDR,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [31:0] S_ARADDR,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	input wire logic CMP_A_RESULT,
	input wire logic CMP_B_RESULT,
	input wire logic [7:0] PORT_PIN_IN,
	input wire logic HF_OSC_ENABLED,
	input wire logic VDETECT_ENABLED,
	input wire logic BROWNOUT_ENABLED,
	output logic MISMATCH_UPDATE,
	output logic CMP_A_REF_SEL_DIVIDER,
	output logic CMP_B_REF_SEL_DIVIDER,
	output logic CMP_A_NONINV_INTERNAL,
	output logic CMP_B_NONINV_INTERNAL,
	output logic CMP_B_PIN_OUT,
	output logic CMP_B_PIN_OE,
	output logic DIV_ENABLE,
	output logic DIV_RANGE_LOW,
	output logic DIV_SOURCE_EXTERNAL,
	output logic [3:0] DIV_LEVEL,
	output logic [4:0] DIV_TAP,
	output logic DIV_CLAMP,
	output logic DIV_PIN_CONNECT,
	output logic REF_PIN_DIGITAL_OE,
	output logic REF_PIN_INPUT_DISABLE,
	output logic FIXED_REF_ON,
	output logic FIXED_REF_STABLE
);
	// synchronisers: first stage read only by second
	logic [12:0] sync_a, sync_b;
	logic cmp_a_s, cmp_b_s, any_other_user;
	logic [7:0] pin_s;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			sync_a <= 13'h0000;
			sync_b <= 13'h0000;
		end
		else
		begin
			sync_a <= {CMP_A_RESULT, BROWNOUT_ENABLED, VDETECT_ENABLED, HF_OSC_ENABLED,
				PORT_PIN_IN, CMP_B_RESULT};
			sync_b <= sync_a;
		end
	end
	assign cmp_b_s = sync_b[0];
	assign pin_s = sync_b[8:1];
	assign any_other_user = |sync_b[11:9];
	assign cmp_a_s = sync_b[12]; // one chain for both results keeps the mirror free of skew

	// write channel
	logic aw_full, w_full, aw_fire, w_fire, do_write;
	logic [31:0] wa, wd;
	logic [3:0] ws;
	logic next_aw_full, next_w_full, next_bvalid;

	assign aw_fire = S_AWVALID && S_AWREADY;
	assign w_fire = S_WVALID && S_WREADY;
	assign do_write = aw_full && w_full && !S_BVALID;
	assign next_aw_full = (aw_full || aw_fire) && !do_write;
	assign next_w_full = (w_full || w_fire) && !do_write;
	assign next_bvalid = do_write || (S_BVALID && !S_BREADY);

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wa <= 32'h0000_0000;
			wd <= 32'h0000_0000;
			ws <= 4'h0;
			S_AWREADY <= 1'b0;
			S_WREADY <= 1'b0;
			S_BVALID <= 1'b0;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			if (aw_fire)
				wa <= S_AWADDR;
			if (w_fire)
			begin
				wd <= S_WDATA;
				ws <= S_WSTRB;
			end
			S_AWREADY <= !next_aw_full;
			S_WREADY <= !next_w_full;
			S_BVALID <= next_bvalid;
		end
	end

	// write decode; registers are one byte, lane 0
	logic wa_mir, wa_div, wa_fix, wa_pin, wa_port, wa_ana, wa_hit, wr_lane;
	assign wa_mir = (wa == crc_pkg::OFF_MIRROR_REFSEL);
	assign wa_div = (wa == crc_pkg::OFF_DIVIDER_CTRL);
	assign wa_fix = (wa == crc_pkg::OFF_FIXED_CTRL);
	assign wa_pin = (wa == crc_pkg::OFF_CMP_PIN_CTRL);
	assign wa_port = (wa == crc_pkg::OFF_PORT_READ);
	assign wa_ana = (wa == crc_pkg::OFF_ANALOG_SELECT);
	assign wa_hit = wa_mir || wa_div || wa_fix || wa_pin || wa_port || wa_ana;
	assign wr_lane = do_write && ws[0];

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
			S_BRESP <= crc_pkg::RESP_OKAY;
		else if (do_write)
			S_BRESP <= wa_hit ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
	end

	// control registers; only RST_N clears them, so sleep and wake leave them be
	logic [7:0] mirror_sel, divctl, pinctl, analog_sel;
	logic [7:0] next_mirror_sel, next_divctl, next_pinctl, next_analog_sel;
	logic fix_en, next_fix_en;

	assign next_mirror_sel = (wr_lane && wa_mir) ?
		(wd[7:0] & crc_pkg::MIRROR_WMASK) : mirror_sel;
	assign next_divctl = (wr_lane && wa_div) ? wd[7:0] : divctl;
	assign next_fix_en = (wr_lane && wa_fix) ? wd[crc_pkg::FIX_EN_BIT] : fix_en;
	assign next_pinctl = (wr_lane && wa_pin) ?
		(wd[7:0] & crc_pkg::PIN_CTRL_WMASK) : pinctl;
	assign next_analog_sel = (wr_lane && wa_ana) ? wd[7:0] : analog_sel;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			mirror_sel <= crc_pkg::RST_MIRROR;
			divctl <= crc_pkg::RST_DIVIDER;
			fix_en <= 1'b0;
			pinctl <= crc_pkg::RST_PIN_CTRL;
			analog_sel <= crc_pkg::RST_ANALOG;
		end
		else
		begin
			mirror_sel <= next_mirror_sel;
			divctl <= next_divctl;
			fix_en <= next_fix_en;
			pinctl <= next_pinctl;
			analog_sel <= next_analog_sel;
		end
	end

	// analog controls follow the next value so they move on the write edge
	logic n_range_low, next_fixed_on;
	logic [3:0] n_level;
	logic [4:0] next_tap;
	assign n_range_low = next_divctl[crc_pkg::DIV_RANGE_BIT];
	assign n_level = next_divctl[crc_pkg::DIV_LEVEL_MSB:0];
	assign next_tap = n_range_low ? {1'b0, n_level} :
		(crc_pkg::DIV_HIGH_BASE + {1'b0, n_level});

	assign next_fixed_on = next_fix_en || any_other_user;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			DIV_ENABLE <= 1'b0;
			DIV_RANGE_LOW <= 1'b0;
			DIV_SOURCE_EXTERNAL <= 1'b0;
			DIV_LEVEL <= 4'h0;
			DIV_TAP <= crc_pkg::DIV_HIGH_BASE;
			DIV_CLAMP <= 1'b0;
			DIV_PIN_CONNECT <= 1'b0;
			REF_PIN_DIGITAL_OE <= 1'b0;
			REF_PIN_INPUT_DISABLE <= 1'b0;
			CMP_A_REF_SEL_DIVIDER <= 1'b0;
			CMP_B_REF_SEL_DIVIDER <= 1'b0;
			CMP_A_NONINV_INTERNAL <= 1'b0;
			CMP_B_NONINV_INTERNAL <= 1'b0;
			FIXED_REF_ON <= 1'b0;
		end
		else
		begin
			DIV_ENABLE <= next_divctl[crc_pkg::DIV_EN_BIT];
			DIV_RANGE_LOW <= n_range_low;
			DIV_SOURCE_EXTERNAL <= next_divctl[crc_pkg::DIV_SRC_BIT];
			DIV_LEVEL <= n_level;
			DIV_TAP <= next_tap;
			DIV_CLAMP <= !next_divctl[crc_pkg::DIV_EN_BIT] && n_range_low
				&& (n_level == 4'h0);
			DIV_PIN_CONNECT <= next_divctl[crc_pkg::DIV_OE_BIT];
			// pin output enable wins over the direction bit
			REF_PIN_DIGITAL_OE <= !next_divctl[crc_pkg::DIV_OE_BIT]
				&& !next_pinctl[crc_pkg::PC_REF_DIR_BIT];
			REF_PIN_INPUT_DISABLE <= next_divctl[crc_pkg::DIV_OE_BIT];
			CMP_A_REF_SEL_DIVIDER <= next_mirror_sel[crc_pkg::RSEL_A_BIT];
			CMP_B_REF_SEL_DIVIDER <= next_mirror_sel[crc_pkg::RSEL_B_BIT];
			CMP_A_NONINV_INTERNAL <= next_pinctl[crc_pkg::PC_A_NONINV_BIT];
			CMP_B_NONINV_INTERNAL <= next_pinctl[crc_pkg::PC_B_NONINV_BIT];
			FIXED_REF_ON <= next_fixed_on;
		end
	end

	// comparator B pin driver
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			CMP_B_PIN_OE <= 1'b0;
			CMP_B_PIN_OUT <= 1'b0;
		end
		else
		begin
			CMP_B_PIN_OE <= pinctl[crc_pkg::PC_B_OE_BIT] && pinctl[crc_pkg::PC_B_ON_BIT]
				&& !pinctl[crc_pkg::PC_B_DIR_BIT];
			CMP_B_PIN_OUT <= cmp_b_s;
		end
	end

	// settle timer restarts whenever the reference drops out
	logic [crc_pkg::SETTLE_W-1:0] settle_cnt;
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			settle_cnt <= '0;
			FIXED_REF_STABLE <= 1'b0;
		end
		else if (!FIXED_REF_ON || !next_fixed_on) // flag never outlives the reference
		begin
			settle_cnt <= '0;
			FIXED_REF_STABLE <= 1'b0;
		end
		else if (settle_cnt == crc_pkg::SETTLE_LAST)
			FIXED_REF_STABLE <= 1'b1;
		else
			settle_cnt <= settle_cnt + 1'b1;
	end

	// read channel
	logic ar_fire, next_rvalid;
	logic ra_mir, ra_div, ra_fix, ra_pin, ra_port, ra_ana, ra_hit;
	logic [7:0] rd_mirror, rd_div, rd_fix, rd_port, ref_pin_mask, rd_byte;

	assign ar_fire = S_ARVALID && S_ARREADY;
	assign next_rvalid = ar_fire || (S_RVALID && !S_RREADY);
	assign ra_mir = (S_ARADDR == crc_pkg::OFF_MIRROR_REFSEL);
	assign ra_div = (S_ARADDR == crc_pkg::OFF_DIVIDER_CTRL);
	assign ra_fix = (S_ARADDR == crc_pkg::OFF_FIXED_CTRL);
	assign ra_pin = (S_ARADDR == crc_pkg::OFF_CMP_PIN_CTRL);
	assign ra_port = (S_ARADDR == crc_pkg::OFF_PORT_READ);
	assign ra_ana = (S_ARADDR == crc_pkg::OFF_ANALOG_SELECT);
	assign ra_hit = ra_mir || ra_div || ra_fix || ra_pin || ra_port || ra_ana;
	// one snapshot of both results avoids skew between them
	assign rd_mirror = {cmp_a_s, cmp_b_s, mirror_sel[crc_pkg::RSEL_A_BIT],
		mirror_sel[crc_pkg::RSEL_B_BIT], 4'h0};
	assign rd_div = divctl;
	assign rd_fix = {fix_en, FIXED_REF_STABLE, 6'h00};
	assign ref_pin_mask = divctl[crc_pkg::DIV_OE_BIT] ?
		(8'h01 << crc_pkg::REF_PIN_IDX) : 8'h00;
	assign rd_port = pin_s & ~analog_sel & ~ref_pin_mask;
	assign rd_byte = ra_mir ? rd_mirror :
		ra_div ? rd_div :
		ra_fix ? rd_fix :
		ra_pin ? pinctl :
		ra_port ? rd_port :
		ra_ana ? analog_sel : 8'h00;

	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			S_ARREADY <= 1'b0;
			S_RVALID <= 1'b0;
			S_RDATA <= 32'h0000_0000;
			S_RRESP <= crc_pkg::RESP_OKAY;
			MISMATCH_UPDATE <= 1'b0;
		end
		else
		begin
			S_ARREADY <= !next_rvalid;
			S_RVALID <= next_rvalid;
			if (ar_fire)
			begin
				S_RDATA <= {24'h00_0000, rd_byte};
				S_RRESP <= ra_hit ? crc_pkg::RESP_OKAY : crc_pkg::RESP_SLVERR;
			end
			// only the comparator control read refreshes the mismatch latches
			MISMATCH_UPDATE <= ar_fire && ra_pin;
		end
	end

	// checks
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	logic [crc_pkg::SETTLE_W-1:0] on_cycles;
	always_ff @(posedge MCLK)
	begin
		if (!RST_N || !FIXED_REF_ON)
			on_cycles <= '0;
		else if (on_cycles != crc_pkg::SETTLE_LAST)
			on_cycles <= on_cycles + 1'b1;
	end

	sequence s_div_write;
		wr_lane && wa_div;
	endsequence

	sequence s_mirror_read;
		ar_fire && ra_mir;
	endsequence

	a_mirror_no_latch:
	assert property (s_mirror_read |=> !MISMATCH_UPDATE)
	else $error("mirror read pulsed mismatch update");
	a_mirror_packing:
	assert property (s_mirror_read |=> S_RVALID && S_RDATA[3:0] == 4'h0
		&& S_RDATA[7] == $past(cmp_a_s) && S_RDATA[6] == $past(cmp_b_s))
	else $error("mirror read data wrong");
	a_tap_value:
	assert property (s_div_write |=> DIV_TAP == ($past(wd[crc_pkg::DIV_RANGE_BIT]) ?
		{1'b0, $past(wd[3:0])} : crc_pkg::DIV_HIGH_BASE + {1'b0, $past(wd[3:0])}))
	else $error("divider tap wrong after write");
	a_div_follows:
	assert property (s_div_write |=> DIV_ENABLE == $past(wd[crc_pkg::DIV_EN_BIT])
		&& DIV_PIN_CONNECT == $past(wd[crc_pkg::DIV_OE_BIT]))
	else $error("divider enable did not follow write");
	a_clamp_cause:
	assert property (DIV_CLAMP |-> !DIV_ENABLE && DIV_RANGE_LOW && DIV_LEVEL == 4'h0)
	else $error("clamp without its conditions");
	a_ref_pin_zero:
	assert property (ar_fire && ra_port && DIV_PIN_CONNECT
		|=> S_RDATA[crc_pkg::REF_PIN_IDX] == 1'b0)
	else $error("reference pin read nonzero");
	a_ref_override:
	assert property (DIV_PIN_CONNECT |-> !REF_PIN_DIGITAL_OE && REF_PIN_INPUT_DISABLE)
	else $error("reference pin driver not overridden");
	a_cmpb_pin_gate:
	assert property (!pinctl[crc_pkg::PC_B_ON_BIT] ##1 !pinctl[crc_pkg::PC_B_ON_BIT]
		|-> !CMP_B_PIN_OE)
	else $error("comparator pin driven while off");
	a_fixed_others:
	assert property (any_other_user |=> FIXED_REF_ON)
	else $error("fixed reference off with another user");
	a_stable_settled:
	assert property (FIXED_REF_STABLE |-> FIXED_REF_ON && on_cycles == crc_pkg::SETTLE_LAST)
	else $error("stable flag before settle time");
	a_write_answer:
	assert property (aw_full && w_full && !S_BVALID |=> S_BVALID)
	else $error("write not answered");

endmodule // crc_top
`default_nettype wire
